// File: common/dsc_params.svh
// Purpose: constants for the drive stop and coast restart control
// Assumes: 250 MHz core clock, registers reached over APB
// Notes: frequency in 0.01 Hz, current in 0.001 x rated, time in 0.01 s, retry wait in 0.1 s
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DSC_OFS_CTRL 8'h00
`define DSC_OFS_RETRY 8'h04
`define DSC_OFS_FLOOR 8'h08
`define DSC_OFS_RCUR 8'h0C
`define DSC_OFS_RDEC 8'h10
`define DSC_OFS_ASGN_LO 8'h14
`define DSC_OFS_ASGN_HI 8'h18
`define DSC_OFS_FREQ 8'h1C
`define DSC_OFS_BASE 8'h20
`define DSC_OFS_RAMP 8'h24
`define DSC_OFS_STAT 8'h28
`define DSC_OFS_OUTF 8'h2C
// ----------------------------------------
// setting codes
// ----------------------------------------
`define DSC_SRC_PANEL 2'h2
`define DSC_KEY_ON 2'h0
`define DSC_KEY_OFF 2'h1
`define DSC_STOP_COAST 1'b1
`define DSC_RST_ZERO 2'h0
`define DSC_RST_FMATCH 2'h1
`define DSC_RST_ACTIVE 2'h2
`define DSC_SF_MAX 2'h1
`define DSC_SF_SET 2'h2
`define DSC_FUNC_COAST 8'h0B
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define DSC_RETRY_RST 16'h000A
`define DSC_RETRY_MIN 16'h0003
`define DSC_RETRY_MAX 16'h03E8
`define DSC_FLOOR_RST 16'h0000
`define DSC_FLOOR_MAX 16'h9C40
`define DSC_RCUR_RST 16'h03E8
`define DSC_RCUR_MIN 16'h00C8
`define DSC_RCUR_MAX_SMALL 16'h07D0
`define DSC_RCUR_MAX_LARGE 16'h0708
`define DSC_RDEC_RST 16'h0032
`define DSC_RDEC_MIN 16'h000A
`define DSC_RDEC_MAX 16'h0BB8
`define DSC_SETF_RST 16'h1388
`define DSC_MAXF_RST 16'h1770
`define DSC_BASEF_RST 16'h1388
`define DSC_RAMP_RST 16'h03E8
// ----------------------------------------
// timing
// ----------------------------------------
`define DSC_CLK_PERIOD_NS 4
`define DSC_HUND_NS 10000000
`define DSC_HUND_CYCLES (`DSC_HUND_NS / `DSC_CLK_PERIOD_NS)
`define DSC_HUND_PER_TENTH 16'h000A
`endif

// File: common/dsc_pkg.sv
// Purpose: types of the drive stop and coast restart control
// Assumes: widths of the values in the constants header
// Notes: bus, measurement and drive ports travel as packed structs
`default_nettype none
package dsc_pkg;
  typedef enum logic [2:0] {
    DSC_IDLE, DSC_RUN, DSC_DECEL, DSC_COAST, DSC_WAIT, DSC_MATCH
  } dsc_mode_type;

  typedef struct packed {
    logic [1:0] restart_start_freq_select;
    logic [1:0] coast_restart_mode_select;
    logic stop_mode_select;
    logic [1:0] panel_stop_key_select;
    logic [1:0] run_source_select;
  } dsc_ctrl_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dsc_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsc_apb_rsp_type;

  typedef struct packed {
    logic [15:0] residual_freq;
    logic volt_match;
    logic [15:0] out_current;
  } dsc_meas_type;

  typedef struct packed {
    logic gate_on;
    logic [15:0] out_freq;
    logic climit_en;
    logic [15:0] climit_level;
    logic trip_reset;
  } dsc_drive_type;

  typedef struct packed {
    dsc_mode_type mode;
    dsc_ctrl_type ctrl;
    logic [15:0] retry;
    logic [15:0] floor;
    logic [15:0] rcur;
    logic [15:0] rdec;
    logic [63:0] asgn;
    logic [15:0] setf;
    logic [15:0] maxf;
    logic [15:0] basef;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [1:0] key_prev;
    logic coast_prev;
    logic run_latch;
    logic kill_latch;
    logic [15:0] int_freq;
    logic [15:0] target;
    logic [31:0] hund_cnt;
    logic tick;
    logic [23:0] acc;
    logic [15:0] wait_cnt;
    dsc_apb_rsp_type rsp;
    dsc_drive_type drv;
  } dsc_state_type;
endpackage : dsc_pkg

`default_nettype wire

// File: design/dsc_stop_ctrl.sv
// Purpose: stop key, stop mode and coast restart control of a motor drive
// Assumes: pins synchronised here, measurements on the core clock
// Notes: one 10 ms tick paces every ramp and the retry wait
//
// Contract
// - stop key setting matters only when runs come from terminals
// - panel run source: panel key always stops and resets trips
// - key code 00 stop+reset, 01 neither, 02 reset only
// - stop mode 00 ramps down over decel time, 01 coasts
// - stop mode applies to panel and terminal stops alike
// - run during coasting restarts through the restart mode
// - coast-stop active switches output stage off
// - coast-stop taken from any of eight inputs coded 11
// - coast while asserted, matching restarts after retry wait 0.3 to 100.0 s
// - panel run source: coast release needs a fresh run command
// - restart codes 00 zero start, 01 match, 02 active match
// - matching falls back to zero when detected at or below floor
// - restart mode also governs restarts after trip reset
// - zero start begins at 0 Hz and skips the retry wait
// - matching locks onto motor frequency after the wait
// - matching may start at zero below half base frequency
// - active match start frequency: interrupt, maximum or set
// - active match ramps down at restart decel, current held
// - restart current 0.20 to 2.00 (large 1.80) rated, default 1.00
// - on voltage match ramp back to the set frequency
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"

module dsc_stop_ctrl #(
  parameter int unsigned HUND_CYCLES = `DSC_HUND_CYCLES,
  parameter bit LARGE_UNIT = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire dsc_pkg::dsc_apb_req_type apb_req,
  output var dsc_pkg::dsc_apb_rsp_type apb_rsp,
  // terminal and panel pins
  input wire logic term_run,
  input wire logic [7:0] mfi,
  input wire logic panel_run_key,
  input wire logic panel_stop_key,
  // trip state and measurements
  input wire logic trip_active,
  input wire dsc_pkg::dsc_meas_type meas,
  // drive outputs
  output var dsc_pkg::dsc_drive_type drive
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) r = lo;
    if (v > hi) r = hi;
    return r;
  endfunction : clamp16

  function automatic logic coast_hit(input logic [63:0] asgn,
                                     input logic [7:0] lines);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (lines[i] && asgn[i*8 +: 8] == `DSC_FUNC_COAST) hit = 1'b1;
    end
    return hit;
  endfunction : coast_hit

  dsc_pkg::dsc_state_type st;
  dsc_pkg::dsc_state_type n;

  logic panel_src;
  logic term_s;
  logic coast_act;
  logic coast_req;
  logic coast_fall;
  logic run_key_press;
  logic stop_key_press;
  logic stop_key_act;
  logic reset_key_act;
  logic run_req;
  logic [15:0] rcur_max;
  logic [15:0] rcur_eff;
  logic [15:0] rdec_eff;
  logic [15:0] floor_eff;
  logic [15:0] wait_tgt;
  logic wait_done;
  logic half_base_low;
  logic bus_access;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  assign panel_src = st.ctrl.run_source_select == `DSC_SRC_PANEL;
  assign term_s = st.sync2[0];
  assign coast_act = coast_hit(st.asgn, st.sync2[10:3]);
  // a trip cuts the output like a coast-stop, so its reset resumes alike
  assign coast_req = coast_act | trip_active;
  assign coast_fall = st.coast_prev & ~coast_act;
  assign run_key_press = st.sync2[1] & ~st.key_prev[0];
  assign stop_key_press = st.sync2[2] & ~st.key_prev[1];
  assign stop_key_act = stop_key_press & ~trip_active &
    (panel_src | st.ctrl.panel_stop_key_select == `DSC_KEY_ON);
  assign reset_key_act = stop_key_press & trip_active &
    (panel_src | st.ctrl.panel_stop_key_select != `DSC_KEY_OFF);
  assign run_req = panel_src ? st.run_latch : (term_s & ~st.kill_latch);
  assign rcur_max = LARGE_UNIT ? `DSC_RCUR_MAX_LARGE : `DSC_RCUR_MAX_SMALL;
  assign rcur_eff = clamp16(st.rcur, `DSC_RCUR_MIN, rcur_max);
  assign rdec_eff = clamp16(st.rdec, `DSC_RDEC_MIN, `DSC_RDEC_MAX);
  assign floor_eff = clamp16(st.floor, 16'h0000, `DSC_FLOOR_MAX);
  assign wait_tgt = 16'(clamp16(st.retry, `DSC_RETRY_MIN, `DSC_RETRY_MAX) *
    `DSC_HUND_PER_TENTH);
  assign wait_done = st.mode == dsc_pkg::DSC_WAIT && !coast_req && run_req &&
    st.wait_cnt >= wait_tgt;
  assign half_base_low = st.int_freq <= {1'b0, st.basef[15:1]};
  assign bus_access = apb_req.psel & apb_req.penable;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic [23:0] acc_in;
  logic [15:0] rate;
  logic step_ok;

  always_comb begin
    n = st;
    acc_in = st.acc + (st.tick ? 24'(st.maxf) : 24'h000000);
    rate = st.accel;
    step_ok = 1'b1;
    // pins: the first stage feeds only the second
    n.sync1 = {mfi, panel_stop_key, panel_run_key, term_run};
    n.sync2 = st.sync1;
    n.key_prev = st.sync2[2:1];
    n.coast_prev = coast_act;
    n.drv.trip_reset = reset_key_act;
    // tick
    n.tick = 1'b0;
    n.hund_cnt = st.hund_cnt + 32'h00000001;
    if (st.hund_cnt >= 32'(HUND_CYCLES - 1)) begin
      n.hund_cnt = 32'h00000000;
      n.tick = 1'b1;
    end
    // run and stop latches
    if (run_key_press) n.run_latch = 1'b1;
    if (stop_key_act || trip_active || (coast_fall && panel_src)) begin
      n.run_latch = 1'b0;
    end
    if (!term_s) n.kill_latch = 1'b0;
    if (stop_key_act && !panel_src) n.kill_latch = 1'b1;
    // ramp: acc gains maxf per tick, one 0.01 Hz step per rate drained
    if (st.mode == dsc_pkg::DSC_MATCH) begin
      rate = rdec_eff;
      step_ok = meas.out_current <= rcur_eff;
    end else if (st.drv.out_freq > st.target) begin
      rate = st.decel;
    end
    if (rate == 16'h0000) rate = 16'h0001;
    n.acc = acc_in;
    if (st.drv.out_freq == st.target) begin
      n.acc = 24'h000000;
    end else if (step_ok && acc_in >= 24'(rate)) begin
      n.acc = acc_in - 24'(rate);
      if (st.drv.out_freq > st.target) begin
        n.drv.out_freq = st.drv.out_freq - 16'h0001;
      end else begin
        n.drv.out_freq = st.drv.out_freq + 16'h0001;
      end
    end
    // mode sequence
    if (coast_req) begin
      if (st.drv.gate_on) n.int_freq = st.drv.out_freq;
      n.mode = dsc_pkg::DSC_COAST;
      n.drv.out_freq = 16'h0000;
    end else begin
      unique case (st.mode)
        dsc_pkg::DSC_IDLE: begin
          n.drv.out_freq = 16'h0000;
          if (run_req) n.mode = dsc_pkg::DSC_RUN;
        end
        dsc_pkg::DSC_RUN, dsc_pkg::DSC_DECEL: begin
          if (!run_req) begin
            if (st.ctrl.stop_mode_select == `DSC_STOP_COAST) begin
              n.int_freq = st.drv.out_freq;
              n.mode = dsc_pkg::DSC_COAST;
              n.drv.out_freq = 16'h0000;
            end else if (st.drv.out_freq == 16'h0000) begin
              n.mode = dsc_pkg::DSC_IDLE;
            end else begin
              n.mode = dsc_pkg::DSC_DECEL;
            end
          end else begin
            n.mode = dsc_pkg::DSC_RUN;
          end
        end
        dsc_pkg::DSC_COAST: begin
          n.drv.out_freq = 16'h0000;
          if (run_req && !(coast_fall && panel_src)) begin
            if (st.ctrl.coast_restart_mode_select == `DSC_RST_ZERO) begin
              n.mode = dsc_pkg::DSC_RUN;
            end else begin
              n.mode = dsc_pkg::DSC_WAIT;
              n.wait_cnt = 16'h0000;
            end
          end
        end
        dsc_pkg::DSC_WAIT: begin
          n.drv.out_freq = 16'h0000;
          if (st.tick) n.wait_cnt = st.wait_cnt + 16'h0001;
          if (!run_req) begin
            n.mode = dsc_pkg::DSC_COAST;
          end else if (wait_done) begin
            if (st.ctrl.coast_restart_mode_select == `DSC_RST_ACTIVE) begin
              n.mode = dsc_pkg::DSC_MATCH;
              n.drv.out_freq = st.int_freq;
              if (st.ctrl.restart_start_freq_select == `DSC_SF_MAX) begin
                n.drv.out_freq = st.maxf;
              end
              if (st.ctrl.restart_start_freq_select == `DSC_SF_SET) begin
                n.drv.out_freq = st.setf;
              end
            end else begin
              n.mode = dsc_pkg::DSC_RUN;
              if (meas.residual_freq > floor_eff && !half_base_low) begin
                n.drv.out_freq = meas.residual_freq;
              end
            end
          end
        end
        dsc_pkg::DSC_MATCH: begin
          if (!run_req) begin
            n.mode = (st.ctrl.stop_mode_select == `DSC_STOP_COAST) ?
              dsc_pkg::DSC_COAST : dsc_pkg::DSC_DECEL;
          end else if (meas.volt_match) begin
            n.mode = dsc_pkg::DSC_RUN;
          end
        end
        default: n.mode = dsc_pkg::DSC_IDLE;
      endcase
    end
    n.target = (n.mode == dsc_pkg::DSC_RUN) ? st.setf : 16'h0000;
    n.drv.gate_on = n.mode == dsc_pkg::DSC_RUN ||
      n.mode == dsc_pkg::DSC_DECEL || n.mode == dsc_pkg::DSC_MATCH;
    n.drv.climit_en = n.mode == dsc_pkg::DSC_MATCH;
    n.drv.climit_level = rcur_eff;
    // apb: one wait state, write lands on the completing edge
    n.rsp.pready = 1'b0;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata = 32'h00000000;
    if (bus_access && !st.rsp.pready) begin
      n.rsp.pready = 1'b1;
      unique case (apb_req.paddr)
        `DSC_OFS_CTRL: n.rsp.prdata = 32'(st.ctrl);
        `DSC_OFS_RETRY: n.rsp.prdata = 32'(st.retry);
        `DSC_OFS_FLOOR: n.rsp.prdata = 32'(st.floor);
        `DSC_OFS_RCUR: n.rsp.prdata = 32'(st.rcur);
        `DSC_OFS_RDEC: n.rsp.prdata = 32'(st.rdec);
        `DSC_OFS_ASGN_LO: n.rsp.prdata = st.asgn[31:0];
        `DSC_OFS_ASGN_HI: n.rsp.prdata = st.asgn[63:32];
        `DSC_OFS_FREQ: n.rsp.prdata = {st.maxf, st.setf};
        `DSC_OFS_BASE: n.rsp.prdata = 32'(st.basef);
        `DSC_OFS_RAMP: n.rsp.prdata = {st.decel, st.accel};
        `DSC_OFS_STAT: n.rsp.prdata = 32'({st.drv.climit_en, run_req,
          coast_act, st.drv.gate_on, st.mode});
        `DSC_OFS_OUTF: n.rsp.prdata = {st.int_freq, st.drv.out_freq};
        default: n.rsp.pslverr = 1'b1;
      endcase
    end
    if (bus_access && st.rsp.pready && apb_req.pwrite) begin
      unique case (apb_req.paddr)
        `DSC_OFS_CTRL: n.ctrl = apb_req.pwdata[8:0];
        `DSC_OFS_RETRY: n.retry = apb_req.pwdata[15:0];
        `DSC_OFS_FLOOR: n.floor = apb_req.pwdata[15:0];
        `DSC_OFS_RCUR: n.rcur = apb_req.pwdata[15:0];
        `DSC_OFS_RDEC: n.rdec = apb_req.pwdata[15:0];
        `DSC_OFS_ASGN_LO: n.asgn[31:0] = apb_req.pwdata;
        `DSC_OFS_ASGN_HI: n.asgn[63:32] = apb_req.pwdata;
        `DSC_OFS_FREQ: {n.maxf, n.setf} = apb_req.pwdata;
        `DSC_OFS_BASE: n.basef = apb_req.pwdata[15:0];
        `DSC_OFS_RAMP: {n.decel, n.accel} = apb_req.pwdata;
        default: n.rsp.pslverr = 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.retry <= `DSC_RETRY_RST;
      st.floor <= `DSC_FLOOR_RST;
      st.rcur <= `DSC_RCUR_RST;
      st.rdec <= `DSC_RDEC_RST;
      st.setf <= `DSC_SETF_RST;
      st.maxf <= `DSC_MAXF_RST;
      st.basef <= `DSC_BASEF_RST;
      st.accel <= `DSC_RAMP_RST;
      st.decel <= `DSC_RAMP_RST;
    end else begin
      st <= n;
    end
  end

  assign apb_rsp = st.rsp;
  assign drive = st.drv;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_coast_gate_off: assert property (coast_act |=> !drive.gate_on)
    else $error("output stage on while coast-stop active");
  a_panel_no_restart: assert property (
    coast_fall && panel_src |=> !drive.gate_on [*2])
    else $error("panel source restarted on coast release");
  a_key_masked: assert property (
    !panel_src && st.ctrl.panel_stop_key_select == `DSC_KEY_OFF &&
    stop_key_press && term_s && !st.kill_latch |=> !st.kill_latch)
    else $error("disabled stop key stopped the drive");
  a_panel_stop_always: assert property (
    panel_src && stop_key_act && st.mode == dsc_pkg::DSC_RUN |->
    ##2 st.mode inside {dsc_pkg::DSC_DECEL, dsc_pkg::DSC_COAST,
    dsc_pkg::DSC_IDLE})
    else $error("panel stop key ignored");
  a_stop_coasts: assert property (
    st.mode == dsc_pkg::DSC_RUN && !run_req &&
    st.ctrl.stop_mode_select == `DSC_STOP_COAST |=> !drive.gate_on)
    else $error("coast stop mode left output on");
  a_zero_no_wait: assert property (
    st.mode == dsc_pkg::DSC_COAST && !coast_req && run_req && !coast_fall &&
    st.ctrl.coast_restart_mode_select == `DSC_RST_ZERO |=>
    st.mode == dsc_pkg::DSC_RUN && drive.out_freq == 16'h0000)
    else $error("zero start did not start at once from 0 Hz");
  a_wait_holds: assert property (
    st.mode == dsc_pkg::DSC_WAIT && st.wait_cnt < wait_tgt |=>
    !drive.gate_on)
    else $error("restart before retry wait elapsed");
  a_floor_fallback: assert property (
    wait_done && st.ctrl.coast_restart_mode_select == `DSC_RST_FMATCH &&
    meas.residual_freq <= floor_eff |=> drive.out_freq == 16'h0000)
    else $error("matching start ignored the floor");
  a_fmatch_lock: assert property (
    wait_done && st.ctrl.coast_restart_mode_select == `DSC_RST_FMATCH &&
    meas.residual_freq > floor_eff && !half_base_low |=>
    drive.gate_on && drive.out_freq == $past(meas.residual_freq))
    else $error("matching start did not lock on motor frequency");
  a_match_climit: assert property (
    st.mode == dsc_pkg::DSC_MATCH |-> drive.climit_en &&
    drive.climit_level == rcur_eff)
    else $error("restart current not held in active match");
  a_start_max: assert property (
    wait_done && st.ctrl.coast_restart_mode_select == `DSC_RST_ACTIVE &&
    st.ctrl.restart_start_freq_select == `DSC_SF_MAX |=>
    drive.out_freq == $past(st.maxf))
    else $error("active match began from wrong frequency");
  a_trip_reset_key: assert property (
    reset_key_act |=> drive.trip_reset ##1 !drive.trip_reset)
    else $error("trip reset pulse missing");

endmodule : dsc_stop_ctrl

`default_nettype wire

// File: verification/dsc_motor_model.sv
// Purpose: motor and measurement stand-in for the stop control bench
// Assumes: drive outputs change on the core clock
// Notes: the coasting speed is whatever the bench sets on spin
`timescale 1ns/1ps
`default_nettype none

module dsc_motor_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // drive side
  input wire dsc_pkg::dsc_drive_type drive,
  // bench controls
  input wire logic [15:0] spin,
  input wire logic volt_match_in,
  // measurements
  output var dsc_pkg::dsc_meas_type meas
);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meas <= '0;
    end else begin
      // a coasting motor reports the bench speed, a driven one follows
      meas.residual_freq <= drive.gate_on ? drive.out_freq : spin;
      meas.volt_match <= volt_match_in & drive.gate_on;
      // current sits at the hold level so the ramp is never frozen
      meas.out_current <= drive.climit_en ? drive.climit_level : 16'h0100;
    end
  end
endmodule : dsc_motor_model

`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench for the stop and coast restart control
// Assumes: short tick of T cycles, small frequency settings
// Notes: every wait is bounded; a spent bound counts as a failure
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"

module tb_top;
  localparam int T = 250;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  dsc_pkg::dsc_apb_req_type req = '0;
  dsc_pkg::dsc_apb_rsp_type rsp;
  logic term_run = 1'h0;
  logic [7:0] mfi = 8'h00;
  logic prk = 1'h0;
  logic psk = 1'h0;
  logic trip = 1'h0;
  logic vm = 1'h0;
  logic [15:0] spin = 16'h0000;
  dsc_pkg::dsc_meas_type meas;
  dsc_pkg::dsc_drive_type drv;
  int failures = 0;
  int n_tests = 0;
  int n_rst = 0;
  int n;
  logic [31:0] q;
  logic e;

  always #2 clk = ~clk;
  always @(posedge clk) if (drv.trip_reset === 1'h1) n_rst++;

  dsc_stop_ctrl #(.HUND_CYCLES(T), .LARGE_UNIT(1'h0)) u_dsc_stop_ctrl (
    .clk(clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
    .term_run(term_run), .mfi(mfi), .panel_run_key(prk),
    .panel_stop_key(psk), .trip_active(trip), .meas(meas), .drive(drv));
  dsc_motor_model u_dsc_motor_model (.clk(clk), .reset_n(reset_n),
    .drive(drv), .spin(spin), .volt_match_in(vm), .meas(meas));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'h1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    req <= '{1'h1, 1'h0, w, a, d};
    @(posedge clk);
    req.penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'h1 && k < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge clk);
    if (k == 20) begin
      chk(1'h0, "bus hang");
      results();
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q === x, "read value");
  endtask : rd

  task automatic cfg(input logic [1:0] s, k, input logic m,
                     input logic [1:0] r, f);
    apb(1'h1, `DSC_OFS_CTRL, {23'h0, f, r, m, k, s});
  endtask : cfg

  // wait for the output stage to reach v, cycles taken left in n
  task automatic wg(input logic v, input int lim);
    n = 0;
    while (drv.gate_on !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (drv.gate_on !== v) begin
      chk(1'h0, "gate wait bound");
      results();
    end
  endtask : wg

  // key held long enough to pass the synchroniser and edge detect
  task automatic key(input logic stop);
    if (stop) psk <= 1'h1;
    else prk <= 1'h1;
    cyc(6);
    psk <= 1'h0;
    prk <= 1'h0;
    cyc(6);
  endtask : key

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(`DSC_OFS_CTRL, 32'h0);
    rd(`DSC_OFS_RETRY, 32'h000A);
    rd(`DSC_OFS_FLOOR, 32'h0);
    rd(`DSC_OFS_RCUR, 32'h03E8);
    rd(`DSC_OFS_RDEC, 32'h0032);
    apb(1'h0, 8'h30, 32'h0);
    chk(e === 1'h1, "unmapped read");
    apb(1'h1, `DSC_OFS_FREQ, 32'h00640032);
    apb(1'h1, `DSC_OFS_BASE, 32'h00000014);
    apb(1'h1, `DSC_OFS_RAMP, 32'h00020002);
    apb(1'h1, `DSC_OFS_RETRY, 32'h00000003);
    apb(1'h1, `DSC_OFS_RDEC, 32'h0000000A);
    apb(1'h1, `DSC_OFS_RCUR, 32'h0000FFFF);
    cyc(1);
    chk(drv.climit_level === 16'h07D0, "current upper clamp");
    apb(1'h1, `DSC_OFS_RCUR, 32'h00000001);
    cyc(1);
    chk(drv.climit_level === 16'h00C8, "current lower clamp");
    apb(1'h1, `DSC_OFS_RCUR, 32'h000003E8);
    apb(1'h1, `DSC_OFS_ASGN_HI, 32'h0B000000);
    $display("done registers");
  endtask : t_regs

  task automatic t_key;
    for (int c = 0; c < 3; c++) begin
      cfg(2'h1, c[1:0], 1'h1, 2'h0, 2'h0);
      term_run <= 1'h1;
      wg(1'h1, 20);
      key(1'h1);
      chk(drv.gate_on === (c != 0), "stop key");
      term_run <= 1'h0;
      wg(1'h0, 20);
      trip <= 1'h1;
      n_rst = 0;
      key(1'h1);
      trip <= 1'h0;
      chk(n_rst == (c != 1), "key trip reset");
    end
    $display("done stop key codes");
  endtask : t_key

  task automatic t_panel;
    cfg(2'h2, 2'h1, 1'h1, 2'h0, 2'h0);
    key(1'h0);
    wg(1'h1, 20);
    key(1'h1);
    chk(drv.gate_on === 1'h0, "panel stop");
    trip <= 1'h1;
    n_rst = 0;
    key(1'h1);
    trip <= 1'h0;
    chk(n_rst == 1, "panel trip reset");
    $display("done panel source");
  endtask : t_panel

  task automatic t_zero;
    cfg(2'h1, 2'h0, 1'h0, 2'h0, 2'h0);
    term_run <= 1'h1;
    wg(1'h1, 20);
    cyc(3 * T);
    mfi <= 8'h80;
    wg(1'h0, 10);
    cyc(100);
    chk(drv.gate_on === 1'h0, "coast held");
    mfi <= 8'h00;
    wg(1'h1, 10);
    chk(drv.out_freq === 16'h0000, "zero start");
    cyc(3 * T);
    term_run <= 1'h0;
    cyc(10);
    chk(drv.gate_on === 1'h1, "decel keeps output");
    wg(1'h0, 5 * T);
    $display("done zero start and decel");
  endtask : t_zero

  task automatic t_match;
    for (int i = 0; i < 3; i++) begin
      cfg(2'h1, 2'h0, 1'h0, 2'h1, 2'h0);
      apb(1'h1, `DSC_OFS_FLOOR, (i == 1) ? 32'h30 : 32'h0);
      apb(1'h1, `DSC_OFS_BASE, (i == 2) ? 32'h64 : 32'h14);
      term_run <= 1'h1;
      wg(1'h1, 20);
      cyc(3 * T);
      spin <= 16'h0028;
      mfi <= 8'h80;
      wg(1'h0, 10);
      mfi <= 8'h00;
      wg(1'h1, 32 * T);
      chk(n > 28 * T, "retry wait");
      chk(drv.out_freq === ((i == 0) ? 16'h28 : 16'h0),
        "match freq");
    end
    $display("done frequency matching");
  endtask : t_match

  task automatic t_active;
    logic [15:0] x;
    // start from maximum, then from the set frequency
    for (int s = 1; s < 3; s++) begin
      x = (s == 1) ? 16'h0064 : 16'h0032;
      cfg(2'h1, 2'h0, 1'h0, 2'h2, s[1:0]);
      cyc(3 * T);
      mfi <= 8'h80;
      wg(1'h0, 10);
      mfi <= 8'h00;
      wg(1'h1, 32 * T);
      chk(drv.out_freq === x, "active start");
      chk(drv.climit_en === 1'h1, "current hold");
      chk(drv.climit_level === 16'h03E8, "hold level");
      cyc(2 * T);
      chk(drv.out_freq < x, "active ramp down");
      vm <= 1'h1;
      cyc(10);
      chk(drv.climit_en === 1'h0, "match ends hold");
      cyc(4 * T);
      chk(drv.out_freq === 16'h0032, "frequency restored");
      vm <= 1'h0;
    end
    $display("done active matching");
  endtask : t_active

  task automatic t_panel_coast;
    term_run <= 1'h0;
    wg(1'h0, 5 * T);
    cfg(2'h2, 2'h0, 1'h0, 2'h0, 2'h0);
    key(1'h0);
    wg(1'h1, 20);
    mfi <= 8'h80;
    wg(1'h0, 10);
    mfi <= 8'h00;
    cyc(200);
    chk(drv.gate_on === 1'h0, "no restart on release");
    key(1'h0);
    wg(1'h1, 20);
    $display("done panel coast release");
  endtask : t_panel_coast

  // reset in mid-run must bring back the hold level, control, retry and high assignment defaults
  task automatic t_reset;
    reset_n <= 1'h0;
    cyc(5);
    reset_n <= 1'h1;
    cyc(2);
    chk(drv.climit_level === 16'h03E8, "level after reset");
    rd(`DSC_OFS_CTRL, 32'h0);
    rd(`DSC_OFS_RETRY, 32'h000A);
    rd(`DSC_OFS_ASGN_HI, 32'h0);
    $display("done mid-run reset");
  endtask : t_reset

  initial begin
    cyc(5);
    reset_n <= 1'h1;
    cyc(2);
    t_regs();
    t_key();
    t_panel();
    t_zero();
    t_match();
    t_active();
    t_panel_coast();
    t_reset();
    results();
  end
endmodule : tb_top

`default_nettype wire
